// *** hw/tecp_map.svh ***
// constants for the external-count timer input stage and its shared prescaler
`ifndef TECP_MAP_SVH
`define TECP_MAP_SVH

`define TECP_OPT_PSA_BIT 3
`define TECP_OPT_RST_PSA 1'b1
`define TECP_OPT_RST_PS 3'h7
`define TECP_TMR_RST 8'h00
`define TECP_PS_RST 8'h00
`define TECP_WDT_RST 8'h00
`define TECP_WDT_MAX 8'hff

`endif

// *** hw/tecp_pkg.sv ***
// types shared by the timer input stage
package tecp_pkg;
    // option fields that steer the prescaler
    typedef struct packed {
        logic prescaler_assign_select;
        logic [2:0] ps;
    } tecp_opt_t;

    // timer register write strobe with its data
    typedef struct packed {
        logic en;
        logic [7:0] data;
    } tecp_twr_t;

    // quarter phases of one instruction cycle
    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } tecp_phase_t;
endpackage : tecp_pkg

// *** hw/tecp_timer.sv ***
// external count input stage, ripple prescaler, timer and watchdog counter
`timescale 1ns/1ps
`include "tecp_map.svh"

module tecp_timer import tecp_pkg::*; (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic extCountClk,
    input wire tecp_twr_t tmrWr,
    input wire logic optWrEn,
    input wire tecp_opt_t optWr,
    input wire logic wdtClearCmd,
    input wire logic sleepCmd,
    input wire logic wdtOscLevel,
    output logic [7:0] timerCount,
    output logic psaState,
    output logic wdtTimeout
);

    // mask of the watchdog prescale ratio, 2**ps - 1
    function automatic logic [7:0] ratioMask(input logic [2:0] ps);
        ratioMask = 8'((9'h001 << ps) - 9'h001);
    endfunction : ratioMask

    // reset release through two flops
    logic rstMeta_r;
    logic rstSync_r;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // core-side state
    tecp_opt_t optR_r, optR_nxt;
    tecp_phase_t phase_r, phase_nxt;
    logic [1:0] extSync_r, extSync_nxt;
    logic sample_r, sample_nxt;
    logic [7:0] timer_r, timer_nxt;
    logic clrTog_r, clrTog_nxt;
    logic [2:0] wdtOsc_r, wdtOsc_nxt;
    logic [7:0] wdtPs_r, wdtPs_nxt;
    logic [7:0] wdtCnt_r, wdtCnt_nxt;
    logic wdtTimeout_r, wdtTimeout_nxt;
    logic samplePh;
    logic incPulse;
    logic wdtTick;
    logic wdtClr;
    logic wdtStep;

    // link-side state, clocked by the count pin
    logic [1:0] clrSyncL_r, clrSyncL_nxt;
    logic clrSeenL_r, clrSeenL_nxt;
    logic [7:0] psCntL_r, psCntL_nxt;
    logic psOut;

    // ripple divider on the pin; a clear request arrives as a toggle
    always_comb begin
        clrSyncL_nxt = {clrSyncL_r[0], clrTog_r};
        clrSeenL_nxt = clrSyncL_r[1];
        if (clrSyncL_r[1] != clrSeenL_r) begin
            psCntL_nxt = `TECP_PS_RST;
        end else begin
            psCntL_nxt = psCntL_r + 8'h01;
        end
    end

    always_ff @(posedge extCountClk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            clrSyncL_r <= 2'b00;
            clrSeenL_r <= 1'b0;
            psCntL_r <= `TECP_PS_RST;
        end else begin
            clrSyncL_r <= clrSyncL_nxt;
            clrSeenL_r <= clrSeenL_nxt;
            psCntL_r <= psCntL_nxt;
        end
    end

    // divider bit ps halves the pin rate ps+1 times, so its duty is symmetrical
    assign psOut = optR_r.prescaler_assign_select ? extCountClk : psCntL_r[optR_r.ps];

    // quarter phase, pin synchroniser, sampling and timer
    assign samplePh = (phase_r == PH_Q2) || (phase_r == PH_Q4);
    assign incPulse = samplePh && extSync_r[1] && !sample_r;

    always_comb begin
        unique case (phase_r)
            PH_Q1: phase_nxt = PH_Q2;
            PH_Q2: phase_nxt = PH_Q3;
            PH_Q3: phase_nxt = PH_Q4;
            PH_Q4: phase_nxt = PH_Q1;
        endcase
        extSync_nxt = {extSync_r[0], psOut};
        sample_nxt = samplePh ? extSync_r[1] : sample_r;
        if (tmrWr.en) begin
            timer_nxt = tmrWr.data;
        end else if (incPulse) begin
            timer_nxt = timer_r + 8'h01;
        end else begin
            timer_nxt = timer_r;
        end
        clrTog_nxt = clrTog_r ^ (tmrWr.en && !optR_r.prescaler_assign_select);
        optR_nxt = optWrEn ? optWr : optR_r;
    end

    // watchdog tick detection, prescaler and counter
    assign wdtTick = wdtOsc_r[1] && !wdtOsc_r[2];
    assign wdtClr = wdtClearCmd || sleepCmd;
    assign wdtStep = wdtTick && (!optR_r.prescaler_assign_select || (wdtPs_r == ratioMask(optR_r.ps)));

    always_comb begin
        wdtOsc_nxt = {wdtOsc_r[1:0], wdtOscLevel};
        if (wdtClr || !optR_r.prescaler_assign_select) begin
            wdtPs_nxt = `TECP_PS_RST;
        end else if (wdtTick) begin
            wdtPs_nxt = (wdtPs_r == ratioMask(optR_r.ps)) ? `TECP_PS_RST : wdtPs_r + 8'h01;
        end else begin
            wdtPs_nxt = wdtPs_r;
        end
        if (wdtClr) begin
            wdtCnt_nxt = `TECP_WDT_RST;
        end else if (wdtStep) begin
            wdtCnt_nxt = wdtCnt_r + 8'h01;
        end else begin
            wdtCnt_nxt = wdtCnt_r;
        end
        wdtTimeout_nxt = wdtStep && !wdtClr && (wdtCnt_r == `TECP_WDT_MAX);
    end

    // core registers
    always_ff @(posedge core_clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            optR_r <= '{prescaler_assign_select: `TECP_OPT_RST_PSA, ps: `TECP_OPT_RST_PS};
            phase_r <= PH_Q1;
            extSync_r <= 2'b00;
            sample_r <= 1'b0;
            timer_r <= `TECP_TMR_RST;
            clrTog_r <= 1'b0;
            wdtOsc_r <= 3'h0;
            wdtPs_r <= `TECP_PS_RST;
            wdtCnt_r <= `TECP_WDT_RST;
            wdtTimeout_r <= 1'b0;
        end else begin
            optR_r <= optR_nxt;
            phase_r <= phase_nxt;
            extSync_r <= extSync_nxt;
            sample_r <= sample_nxt;
            timer_r <= timer_nxt;
            clrTog_r <= clrTog_nxt;
            wdtOsc_r <= wdtOsc_nxt;
            wdtPs_r <= wdtPs_nxt;
            wdtCnt_r <= wdtCnt_nxt;
            wdtTimeout_r <= wdtTimeout_nxt;
        end
    end

    // outputs straight from flops
    assign timerCount = timer_r;
    assign psaState = optR_r.prescaler_assign_select;
    assign wdtTimeout = wdtTimeout_r;

    // checks on the core domain
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstSync_r);

    a_sample_phase_only: assert property (
        $changed(sample_r) |-> ($past(phase_r) == PH_Q2 || $past(phase_r) == PH_Q4))
        else $error("sample changed outside second or fourth quarter");

    a_edge_reaches_timer: assert property (
        ($rose(extSync_r[1]) && !sample_r) |-> ##[0:1] incPulse)
        else $error("synchronised edge did not reach the timer in time");

    a_timer_increment: assert property (
        (incPulse && !tmrWr.en) |=> (timer_r == $past(timer_r) + 8'h01))
        else $error("timer did not add one on a sampled edge");

    a_timer_holds: assert property (
        (!incPulse && !tmrWr.en) |=> $stable(timer_r))
        else $error("timer moved without a sampled edge");

    a_write_clears_div: assert property (
        (tmrWr.en && !optR_r.prescaler_assign_select) |=> (clrTog_r != $past(clrTog_r)) && (timer_r == $past(tmrWr.data)))
        else $error("timer write did not load and clear the divider");

    a_option_switch: assert property (
        optWrEn |=> (optR_r == $past(optWr)) && (psaState == $past(optWr.prescaler_assign_select)))
        else $error("option write not taken");

    a_wdt_clear_all: assert property (
        (wdtClr && optR_r.prescaler_assign_select) |=> (wdtCnt_r == `TECP_WDT_RST) && (wdtPs_r == `TECP_PS_RST))
        else $error("watchdog clear left counter or prescaler running");

    a_wdt_ratio_step: assert property (
        (wdtTick && optR_r.prescaler_assign_select && !wdtClr && wdtPs_r != ratioMask(optR_r.ps))
            |=> $stable(wdtCnt_r) && (wdtPs_r == $past(wdtPs_r) + 8'h01))
        else $error("watchdog counted before its prescale ratio");

    a_passthru_sample: assert property (
        (optR_r.prescaler_assign_select && $stable(optR_r)) [*3] |-> (extSync_r[1] == $past(extCountClk, 2)))
        else $error("count pin not fed through");

endmodule : tecp_timer

// *** sim/tecp_pulse_src.sv ***
// external pulse source on the count pin
`timescale 1ns/1ps
module tecp_pulse_src (
    output logic extCountClk
);
    // pin stands low outside bursts
    initial extCountClk = 1'b0;
    // n rises, high and low each half ns
    task automatic burst(input int n, input int half);
        repeat (n) begin
            extCountClk = 1'b1;
            #half;
            extCountClk = 1'b0;
            #half;
        end
    endtask : burst
endmodule : tecp_pulse_src

// *** sim/timer_ext_clock_prescaler_tb.sv ***
// self-checking bench for the external count timer stage
`timescale 1ns/1ps
module timer_ext_clock_prescaler_tb import tecp_pkg::*; ();
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic optWrEn = 1'b0;
    logic wdtClearCmd = 1'b0;
    logic sleepCmd = 1'b0;
    logic wdtOscLevel = 1'b0;
    logic extCountClk, psaState, wdtTimeout;
    logic [7:0] timerCount, expCnt, divCnt;
    tecp_twr_t tmrWr = '0;
    tecp_opt_t optWr = '{1'b1, 3'h7};
    int mismatches = 0, tests_run = 0, cycles = 0, wdtHits = 0, clrCnt = 0, n;
    int seed = 32'h394cc794;
    tecp_timer dut_u (.core_clk(core_clk), .reset_n(reset_n), .extCountClk(extCountClk),
        .tmrWr(tmrWr), .optWrEn(optWrEn), .optWr(optWr), .wdtClearCmd(wdtClearCmd),
        .sleepCmd(sleepCmd), .wdtOscLevel(wdtOscLevel), .timerCount(timerCount),
        .psaState(psaState), .wdtTimeout(wdtTimeout));
    tecp_pulse_src src_u (.extCountClk(extCountClk));
    // core clock, run limit and time-out tally
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (wdtTimeout === 1'b1) wdtHits++;
        if (cycles == 60000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    // one pin rise: pending clear, divider step, timer step
    function automatic void rise_model();
        logic [7:0] old;
        old = divCnt;
        divCnt = (clrCnt == 1) ? 8'h00 : divCnt + 8'h01;
        if (clrCnt > 0) clrCnt--;
        if (optWr.prescaler_assign_select) expCnt++;
        else if (!old[optWr.ps] && divCnt[optWr.ps]) expCnt++;
    endfunction : rise_model
    // n pin rises; timer must not move on the edge itself
    task automatic pins(input int n, input int half);
        fork
            src_u.burst(n, half);
            begin
                @(negedge core_clk);
                check(timerCount, expCnt);
            end
        join
        repeat (n) rise_model();
        repeat (8) @(negedge core_clk);
        check(timerCount, expCnt);
        $display("pin test done, %0d rises", n);
    endtask : pins
    task automatic opt(input logic prescaler_assign_select, input logic [2:0] ps);
        optWr = '{prescaler_assign_select, ps};
        optWrEn = 1'b1;
        @(negedge core_clk);
        optWrEn = 1'b0;
        repeat (8) @(negedge core_clk);
        check(psaState, prescaler_assign_select);
    endtask : opt
    // timer write, arming the divider clear when it serves the timer
    task automatic load(input logic [7:0] d);
        tmrWr = '{1'b1, d};
        @(negedge core_clk);
        tmrWr.en = 1'b0;
        expCnt = d;
        if (!optWr.prescaler_assign_select) clrCnt = 3;
        @(negedge core_clk);
        check(timerCount, d);
        if (!optWr.prescaler_assign_select) begin
            // slow rises land the divider clear with no short divider pulse
            src_u.burst(3, 120);
            repeat (3) rise_model();
            repeat (8) @(negedge core_clk);
            check(timerCount, expCnt);
        end
    endtask : load
    task automatic wclear(input logic slp);
        sleepCmd = slp;
        wdtClearCmd = !slp;
        @(negedge core_clk);
        sleepCmd = 1'b0;
        wdtClearCmd = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask : wclear
    task automatic ticks(input int t);
        repeat (t) begin
            wdtOscLevel = 1'b1;
            repeat (3) @(negedge core_clk);
            wdtOscLevel = 1'b0;
            repeat (3) @(negedge core_clk);
        end
    endtask : ticks
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    initial begin
        divCnt = 8'h00;
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        check(timerCount, 8'h00);
        check(psaState, 1'b1);
        // timer fed straight and through the divider, swapped on the fly
        for (int k = 0; k < 9; k++) begin
            n = $random(seed) & 'h3ff;
            if (k % 3 == 0) load(8'(n >> 2));
            wclear(1'b0);
            opt(k % 3 == 0, (k % 3 == 0) ? 3'h7 : 3'(1 + n % 7));
            load(8'(n >> 2));
            pins((k % 3 == 0) ? 1 + n % 20 : 3 + n % 300, (k % 3 == 0) ? 120 : 32);
        end
        // watchdog per tick, then through its prescaler
        for (int k = 0; k < 3; k++) begin
            load(8'h00);
            wclear(1'b0);
            opt(k != 0, 3'(k));
            wdtHits = 0;
            ticks((256 << k) - 1);
            check(8'(wdtHits), 8'h00);
            ticks(1);
            check(8'(wdtHits), 8'h01);
            $display("watchdog test %0d done", k);
        end
        // sleep clears the prescaler as well as the counter
        opt(1'b1, 3'h1);
        wclear(1'b0);
        wdtHits = 0;
        ticks(301);
        wclear(1'b1);
        ticks(511);
        check(8'(wdtHits), 8'h00);
        ticks(1);
        check(8'(wdtHits), 8'h01);
        $display("sleep test done");
        end_sim();
    end
endmodule : timer_ext_clock_prescaler_tb
